// [rtl/alpm_pkg.sv]
// Package for the converter low-power mode controller.
// Assumes a 25 MHz APB clock; shared by the controller, host model, checker and testbench.
package alpm_pkg;
   // Unlock register index and its key; bus address is four times the index
   localparam logic [7:0] ALPM_UNLOCK_INDEX = 8'h05;
   localparam logic [7:0] ALPM_UNLOCK_KEY = 8'h69;
   // Register byte addresses
   localparam logic [11:0] ALPM_UNLOCK_ADDR = {2'h0, ALPM_UNLOCK_INDEX, 2'h0};
   localparam logic [11:0] ALPM_PWRCTL_ADDR = 12'h018;
   localparam logic [11:0] ALPM_STATUS_ADDR = 12'h01C;
   localparam logic [11:0] ALPM_CONV_ADDR = 12'h020;
   // Power control fields
   localparam int ALPM_SLEEP_EN_BIT = 0;
   localparam int ALPM_DEEP_OFF_BIT = 1;
   localparam logic [1:0] ALPM_PWRCTL_RESET = 2'h0;
   // Status fields
   localparam int ALPM_ST_MODE_LSB = 0;
   localparam int ALPM_ST_UNLOCK_BIT = 4;
   localparam int ALPM_ST_READY_BIT = 5;
   localparam int ALPM_ST_WAKE_BIT = 6;
   // Timing
   localparam int ALPM_CLK_MHZ = 25;
   localparam int ALPM_CONV_TIME_NS = 1000;
   localparam int ALPM_CONV_CYCLES = (ALPM_CONV_TIME_NS * ALPM_CLK_MHZ + 999) / 1000;
   localparam int ALPM_LIGHT_WAKE_NS = 2000;
   localparam int ALPM_LIGHT_WAKE_CYCLES = (ALPM_LIGHT_WAKE_NS * ALPM_CLK_MHZ + 999) / 1000;
   localparam int ALPM_RECOVER_NS = 10000;
   localparam int ALPM_RECOVER_CYCLES = (ALPM_RECOVER_NS * ALPM_CLK_MHZ + 999) / 1000;
   localparam int ALPM_CNT_W = 16;
   // Power states, one-hot
   typedef enum logic [3:0] {
      ALPM_NORMAL = 4'h1,
      ALPM_CONVERT = 4'h2,
      ALPM_LIGHT = 4'h4,
      ALPM_DEEP = 4'h8
   } alpm_state_t;
endpackage

// [rtl/alpm_sync.sv]
// Two-flop synchroniser for a pin input.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module alpm_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Data
   input wire logic d,
   output logic q
);
   logic meta_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule
`default_nettype wire

// [rtl/alpm_ctrl.sv]
// Low-power mode controller of a sampling converter with APB registers.
// Assumes an APB master on pclk and conversion_start_select from a pin.
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Normal operation stays powered between conversions, never sleeps unasked.
// - Sleep enabled and select high at conversion end enters light sleep.
// - Light sleep lasts while select stays high.
// - Falling select edge wakes the device from light sleep.
// - With deep off set, next rising select edge enters deep sleep.
// - Deep sleep powers analog off; interface and registers stay alive.
// - In deep sleep the ready indicator is high.
// - Clearing deep off drives ready high as recovery begins.
module alpm_ctrl (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Converter pins
   input wire logic conversion_start_select,
   output logic ready_valid_indicator,
   // Power controls
   output logic analog_on,
   output logic light_sleep_mode,
   output logic deep_sleep_mode,
   output var alpm_pkg::alpm_state_t power_state
);
   import alpm_pkg::*;

   alpm_state_t state_q;
   logic css_s, css_prev_q, css_rise, css_fall;
   logic unlock_q, sleep_en_q, deep_off_q;
   logic [ALPM_CNT_W-1:0] conv_cnt_q, wake_cnt_q;
   logic wake_busy_q, ready_q;
   logic [31:0] prdata_q;
   logic wr, rd, mapped;

   function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ref_a);
      addr_hit = (a == ref_a);
   endfunction

   alpm_sync u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d(conversion_start_select),
      .q(css_s)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         css_prev_q <= 1'b0;
      end else begin
         css_prev_q <= css_s;
      end
   end
   assign css_rise = css_s & ~css_prev_q;
   assign css_fall = ~css_s & css_prev_q;

   // Bus decode
   assign pready = 1'b1;
   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign mapped = addr_hit(paddr, ALPM_UNLOCK_ADDR) | addr_hit(paddr, ALPM_PWRCTL_ADDR)
                 | addr_hit(paddr, ALPM_STATUS_ADDR) | addr_hit(paddr, ALPM_CONV_ADDR);
   assign pslverr = psel & penable & ~mapped;

   // Unlock key; consumed by the next power register write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unlock_q <= 1'b0;
      end else if (wr && addr_hit(paddr, ALPM_UNLOCK_ADDR)) begin
         unlock_q <= (pwdata[7:0] == ALPM_UNLOCK_KEY);
      end else if (wr && addr_hit(paddr, ALPM_PWRCTL_ADDR)) begin
         unlock_q <= 1'b0;
      end
   end

   // Power bits, guarded by the key
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_en_q <= ALPM_PWRCTL_RESET[ALPM_SLEEP_EN_BIT];
         deep_off_q <= ALPM_PWRCTL_RESET[ALPM_DEEP_OFF_BIT];
      end else if (wr && addr_hit(paddr, ALPM_PWRCTL_ADDR) && unlock_q) begin
         sleep_en_q <= pwdata[ALPM_SLEEP_EN_BIT];
         deep_off_q <= pwdata[ALPM_DEEP_OFF_BIT];
      end
   end

   // Power state machine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ALPM_NORMAL;
      end else begin
         case (state_q)
            ALPM_NORMAL: begin
               if (css_rise && deep_off_q) begin
                  state_q <= ALPM_DEEP;
               end else if (css_rise && !wake_busy_q) begin
                  state_q <= ALPM_CONVERT;
               end
            end
            ALPM_CONVERT: begin
               if (conv_cnt_q == ALPM_CNT_W'(ALPM_CONV_CYCLES - 1)) begin
                  if (sleep_en_q && css_s) begin
                     state_q <= ALPM_LIGHT;
                  end else begin
                     state_q <= ALPM_NORMAL;
                  end
               end
            end
            ALPM_LIGHT: begin
               if (css_fall) begin
                  state_q <= ALPM_NORMAL;
               end else begin
                  state_q <= ALPM_LIGHT;
               end
            end
            ALPM_DEEP: begin
               if (!deep_off_q) begin
                  state_q <= ALPM_NORMAL;
               end
            end
            default: state_q <= ALPM_NORMAL;
         endcase
      end
   end

   // Conversion timer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_cnt_q <= '0;
      end else if (state_q == ALPM_CONVERT) begin
         conv_cnt_q <= conv_cnt_q + 1'b1;
      end else begin
         conv_cnt_q <= '0;
      end
   end

   // Wake and recovery timer; new conversions held off while busy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_cnt_q <= '0;
         wake_busy_q <= 1'b0;
      end else if (state_q == ALPM_LIGHT && css_fall) begin
         wake_cnt_q <= ALPM_CNT_W'(ALPM_LIGHT_WAKE_CYCLES - 1);
         wake_busy_q <= 1'b1;
      end else if (state_q == ALPM_DEEP && !deep_off_q) begin
         wake_cnt_q <= ALPM_CNT_W'(ALPM_RECOVER_CYCLES - 1);
         wake_busy_q <= 1'b1;
      end else if (wake_cnt_q != '0) begin
         wake_cnt_q <= wake_cnt_q - 1'b1;
      end else begin
         wake_busy_q <= 1'b0;
      end
   end

   // Ready indicator: high when idle, in deep sleep, or recovering
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_q <= 1'b1;
      end else begin
         case (state_q)
            ALPM_DEEP: ready_q <= 1'b1;
            ALPM_CONVERT: ready_q <= 1'b0;
            default: ready_q <= 1'b1;
         endcase
      end
   end
   assign ready_valid_indicator = ready_q;

   // Analog power follows state; registers untouched in deep sleep
   assign analog_on = (state_q != ALPM_DEEP);
   assign light_sleep_mode = (state_q == ALPM_LIGHT);
   assign deep_sleep_mode = (state_q == ALPM_DEEP);
   assign power_state = state_q;

   // Read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
      end else if (psel && !penable && !pwrite) begin
         prdata_q <= '0;
         if (addr_hit(paddr, ALPM_PWRCTL_ADDR)) begin
            prdata_q[ALPM_SLEEP_EN_BIT] <= sleep_en_q;
            prdata_q[ALPM_DEEP_OFF_BIT] <= deep_off_q;
         end else if (addr_hit(paddr, ALPM_STATUS_ADDR)) begin
            prdata_q[ALPM_ST_MODE_LSB +: 4] <= state_q;
            prdata_q[ALPM_ST_UNLOCK_BIT] <= unlock_q;
            prdata_q[ALPM_ST_READY_BIT] <= ready_q;
            prdata_q[ALPM_ST_WAKE_BIT] <= wake_busy_q;
         end
      end
   end
   assign prdata = rd ? prdata_q : 32'h0000_0000;
endmodule
`default_nettype wire

// [verif/alpm_host.sv]
// Host model driving the select pin on request.
// Assumes req from the bench, changed after rising edges.
`timescale 1ns/10ps
`default_nettype none
module alpm_host
   import alpm_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bench request and pin
   input wire logic req,
   output logic conversion_start_select
);
   int guard_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conversion_start_select <= 1'b0;
         guard_q <= 0;
      end else if (conversion_start_select && !req) begin
         conversion_start_select <= 1'b0;
         guard_q <= ALPM_RECOVER_CYCLES;
      end else if (guard_q != 0) begin
         guard_q <= guard_q - 1;
      end else begin
         conversion_start_select <= req;
      end
   end
endmodule
`default_nettype wire

// [verif/alpm_ctrl_checker.sv]
// Power state assertions for the low-power controller.
// Assumes it is bound to the controller's ports.
`timescale 1ns/10ps
`default_nettype none
module alpm_ctrl_checker (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pins and power controls
   input wire logic conversion_start_select,
   input wire logic ready_valid_indicator,
   input wire logic analog_on,
   input wire logic light_sleep_mode,
   input wire logic deep_sleep_mode,
   input wire alpm_pkg::alpm_state_t power_state
);
   import alpm_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_light_held;
      (light_sleep_mode && conversion_start_select)[*4];
   endsequence
   a_normal_no_sleep: assert property (power_state == ALPM_NORMAL |=> !light_sleep_mode)
      else $error("light sleep entered from normal");
   a_light_from_conv: assert property ($rose(light_sleep_mode) |->
      $past(power_state) == ALPM_CONVERT && conversion_start_select)
      else $error("light sleep entered without conversion end");
   a_conv_length: assert property ($rose(power_state == ALPM_CONVERT) |->
      (power_state == ALPM_CONVERT)[*8] ##17 power_state == ALPM_CONVERT
      ##1 power_state != ALPM_CONVERT)
      else $error("conversion cut short");
   a_light_held: assert property (s_light_held |=> light_sleep_mode)
      else $error("light sleep left with select high");
   a_light_wakes: assert property (light_sleep_mode && $fell(conversion_start_select) |->
      ##[1:5] power_state == ALPM_NORMAL)
      else $error("no wake from light sleep");
   a_deep_entry: assert property ($rose(deep_sleep_mode) |->
      $past(power_state) == ALPM_NORMAL)
      else $error("deep sleep entered from wrong state");
   a_deep_analog: assert property (analog_on != deep_sleep_mode)
      else $error("analog power wrong");
   a_deep_ready: assert property (deep_sleep_mode |-> ready_valid_indicator)
      else $error("ready low in deep sleep");
   a_recover_ready: assert property ($fell(deep_sleep_mode) |->
      ready_valid_indicator && power_state == ALPM_NORMAL)
      else $error("ready low on recovery");
endmodule
bind alpm_ctrl alpm_ctrl_checker u_chk (.pclk(pclk), .presetn(presetn),
   .conversion_start_select(conversion_start_select),
   .ready_valid_indicator(ready_valid_indicator), .analog_on(analog_on),
   .light_sleep_mode(light_sleep_mode), .deep_sleep_mode(deep_sleep_mode),
   .power_state(power_state));
`default_nettype wire

// [verif/alpm_ctrl_tb_top.sv]
// Testbench of the low-power controller: APB calls and pin scenarios.
// Assumes the host model drives the select pin.
`timescale 1ns/10ps
`default_nettype none
module alpm_ctrl_tb_top;
   import alpm_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic host_req = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, slv, sel, ready_valid_indicator, analog_on, light_sleep_mode;
   logic deep_sleep_mode;
   alpm_state_t power_state;
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   always #20 pclk = ~pclk;
   alpm_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .conversion_start_select(sel), .ready_valid_indicator,
      .analog_on, .light_sleep_mode, .deep_sleep_mode, .power_state);
   alpm_host u_host (.pclk, .presetn, .req(host_req), .conversion_start_select(sel));
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
         num_errors++;
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic unlock();
      apb(1'b1, ALPM_UNLOCK_ADDR, {24'h0, ALPM_UNLOCK_KEY});
   endtask
   task automatic conclude();
      $display("checks %0d, errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles > 5000) begin
         num_errors++;
         conclude();
      end
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ALPM_STATUS_ADDR, 32'h0);
      check("status", 32'h21, rd);
      apb(1'b0, 12'h030, 32'h0);
      check("pslverr", 32'h1, slv);
      apb(1'b1, ALPM_PWRCTL_ADDR, 32'h3);
      apb(1'b0, ALPM_PWRCTL_ADDR, 32'h0);
      check("locked ctl", 32'h0, rd);
      host_req <= 1'b1;
      repeat (40) @(posedge pclk);
      check("no sleep", ALPM_NORMAL, power_state);
      host_req <= 1'b0;
      repeat (ALPM_RECOVER_CYCLES + 10) @(posedge pclk);
      unlock();
      apb(1'b1, ALPM_PWRCTL_ADDR, 32'h1);
      host_req <= 1'b1;
      repeat (10) @(posedge pclk);
      check("converting", ALPM_CONVERT, power_state);
      check("ready conv", 32'h0, ready_valid_indicator);
      repeat (30) @(posedge pclk);
      check("light", 32'h1, light_sleep_mode);
      repeat (20) @(posedge pclk);
      check("light held", ALPM_LIGHT, power_state);
      host_req <= 1'b0;
      repeat (6) @(posedge pclk);
      check("woken", ALPM_NORMAL, power_state);
      apb(1'b0, ALPM_STATUS_ADDR, 32'h0);
      check("wake busy", 32'h61, rd);
      repeat (ALPM_RECOVER_CYCLES + 10) @(posedge pclk);
      unlock();
      apb(1'b1, ALPM_PWRCTL_ADDR, 32'h2);
      host_req <= 1'b1;
      repeat (10) @(posedge pclk);
      check("deep", ALPM_DEEP, power_state);
      check("analog", 32'h0, analog_on);
      check("ready deep", 32'h1, ready_valid_indicator);
      check("deep flag", 32'h1, deep_sleep_mode);
      apb(1'b0, ALPM_PWRCTL_ADDR, 32'h0);
      check("kept ctl", 32'h2, rd);
      host_req <= 1'b0;
      unlock();
      apb(1'b1, ALPM_PWRCTL_ADDR, 32'h0);
      repeat (4) @(posedge pclk);
      check("recover", ALPM_NORMAL, power_state);
      check("ready rec", 32'h1, ready_valid_indicator);
      apb(1'b0, ALPM_STATUS_ADDR, 32'h0);
      check("recovering", 32'h61, rd);
      repeat (ALPM_RECOVER_CYCLES) @(posedge pclk);
      apb(1'b0, ALPM_STATUS_ADDR, 32'h0);
      check("recovered", 32'h21, rd);
      host_req <= 1'b1;
      repeat (10) @(posedge pclk);
      check("new conv", ALPM_CONVERT, power_state);
      conclude();
   end
endmodule
`default_nettype wire
